// ==== verilog/pcspc_pkg.sv ====
// socket power control: shared offsets, fields, codes and types
// assumes an 8-bit register window addressed by byte offset
package pcspc_pkg;

    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;

    // register offsets in the socket window
    localparam logic [7:0] OFS_IDENT      = 8'h00;
    localparam logic [7:0] OFS_IF_STATUS  = 8'h01;
    localparam logic [7:0] OFS_POWER_CTRL = 8'h02;

    // power control fields
    localparam int PC_OUT_EN_BIT   = 7;
    localparam int PC_AUTO_SW_BIT  = 5;
    localparam int PC_VCC_EN_BIT   = 4;
    localparam int PC_VCC_REQ_LSB  = 3;
    localparam int PC_VPP_LSB      = 0;

    localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
    localparam logic [7:0] NATIVE_RW_MASK   = 8'hB3;
    localparam logic [7:0] NATIVE_KEEP_MASK = 8'hA0;
    localparam logic [7:0] COMPAT_RW_MASK   = 8'h9B;
    localparam logic [7:0] COMPAT_KEEP_MASK = 8'h9B;

    // identification register
    localparam logic [7:0] IDENT_RESET   = 8'h04;
    localparam logic [7:0] IDENT_RW_MASK = 8'h3F;
    localparam logic [1:0] IFTYPE_VAL    = 2'h2;
    localparam logic [3:0] REV_COMPAT    = 4'h2;
    localparam logic [3:0] REV_NATIVE    = 4'h4;

    // interface status fields
    localparam int ST_CARD_PWR_BIT = 6;
    localparam int ST_CD2_BIT      = 3;
    localparam int ST_CD1_BIT      = 2;

    // request codes
    localparam logic [1:0] VPP_NONE        = 2'h0;
    localparam logic [1:0] VPP_VCC         = 2'h1;
    localparam logic [1:0] VPP_12V         = 2'h2;
    localparam logic [1:0] VCC_REQ_0V      = 2'h0;
    localparam logic [1:0] VCC_REQ_5V      = 2'h2;
    localparam logic [1:0] VCC_REQ_3V3     = 2'h3;

    typedef enum logic [1:0] {
        LAYOUT_NATIVE = 2'b01,
        LAYOUT_COMPAT = 2'b10
    } pcspc_layout_t;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pcspc_reg_req_t;

    typedef struct packed {
        logic vccOn;
        logic vcc3v3;
        logic vppFollow;
        logic vpp12;
    } pcspc_pwr_t;

endpackage

// ==== verilog/pcspc_dual_reset_reg.sv ====
// register with masked write and two reset classes
// assumes rst and busReset synchronous to clock, active high
`timescale 1ns/1ps
module pcspc_dual_reset_reg #(
    parameter int             W         = 8,
    parameter logic [W-1:0]   RESET_VAL = '0
) (
    input  wire logic         clock,     // system clock
    input  wire logic         rst,       // global reset
    input  wire logic         busReset,  // bus reset
    input  wire logic         pmeEnable, // marked bits survive bus reset
    input  wire logic         wrEn,      // write strobe
    input  wire logic [W-1:0] wrData,    // write data
    input  wire logic [W-1:0] wrMask,    // writable bits
    input  wire logic [W-1:0] keepMask,  // marked bits
    output logic      [W-1:0] q          // stored value
);
    logic [W-1:0] nxt_q;
    logic [W-1:0] holdMask;

    always_comb begin
        holdMask = keepMask & {W{pmeEnable}};
        nxt_q    = q;
        if (busReset) begin
            nxt_q = (q & holdMask) | (RESET_VAL & ~holdMask);
        end else if (wrEn) begin
            nxt_q = (wrData & wrMask) | (q & ~wrMask);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= RESET_VAL;
        end else begin
            q <= nxt_q;
        end
    end
endmodule

// ==== verilog/pcspc_power_decode.sv ====
// decodes stored power control bits into switch requests
// assumes card detect already synchronous; purely combinational
`timescale 1ns/1ps
module pcspc_power_decode (
    input  wire pcspc_pkg::pcspc_layout_t layout,         // active layout
    input  wire logic [7:0]               ctrl,           // stored control
    input  wire logic                     vccLevelSelect, // native level
    input  wire logic                     cardSeated,     // both detects on
    output pcspc_pkg::pcspc_pwr_t         pwr             // requests
);
    import pcspc_pkg::*;

    logic [1:0] vppCode;
    logic [1:0] vccCode;

    always_comb begin
        pwr     = '0;
        vppCode = ctrl[PC_VPP_LSB +: 2];
        vccCode = ctrl[PC_VCC_REQ_LSB +: 2];
        unique case (layout)
            LAYOUT_NATIVE: begin
                // auto switch gates vcc on card presence
                pwr.vccOn  = ctrl[PC_VCC_EN_BIT]
                             && (!ctrl[PC_AUTO_SW_BIT] || cardSeated); // R3 R4
                pwr.vcc3v3 = pwr.vccOn && vccLevelSelect; // R4
            end
            LAYOUT_COMPAT: begin
                pwr.vccOn  = (vccCode == VCC_REQ_5V) || (vccCode == VCC_REQ_3V3); // R8
                pwr.vcc3v3 = (vccCode == VCC_REQ_3V3); // R8
            end
            default: begin
                pwr = '0;
            end
        endcase
        // vpp request counts only with vcc on; reserved code means none
        if (pwr.vccOn) begin // R7
            pwr.vppFollow = (vppCode == VPP_VCC); // R6 R10
            pwr.vpp12     = (vppCode == VPP_12V); // R6 R10
        end
    end
endmodule

// ==== verilog/pcspc_socket_power.sv ====
// socket power control register bank with its switch outputs
// assumes a synchronous byte register port and synchronous pins
//
// Overview of operation
// R1 - output enable bit 7 low disables all card outputs, high enables them
// R2 - native layout bit 6 always reads zero
// R3 - native auto-switch bit 5 gates socket power on card detects
// R4 - native bit 4 connects vcc at the system level select, else none
// R5 - native bits 3 and 2 always read zero
// R6 - native vpp: none, follow vcc, 12 V, reserved
// R7 - vpp request ignored while vcc off; compat vcc on at 5 V or 3.3 V
// R8 - compat vcc request bits 4:3: 0 V, 0 V reserved, 5 V, 3.3 V
// R9 - compat bits 6:5 and 2 read zero, writes ignored
// R10 - compat vpp: 0 V, follow vcc, 12 V, 0 V reserved
// R11 - with events enabled marked bits clear only on global reset
// R12 - revision 0010b selects compat layout; resets to 0100b native
// R13 - status bit 6 shows whether socket power is on
// R14 - switch requests held steady, updated the cycle after a write
`timescale 1ns/1ps
module pcspc_socket_power (
    input  wire logic                      clock,            // 100 MHz
    input  wire logic                      rst,              // global reset
    input  wire logic                      busReset,         // bus reset
    input  wire logic                      pmeEnable,        // events on
    input  wire pcspc_pkg::pcspc_reg_req_t regReq,           // reg request
    input  wire logic                      vccLevelSelect,   // 1 = 3.3 V
    input  wire logic                      cardDetect1N,     // detect 1
    input  wire logic                      cardDetect2N,     // detect 2
    output logic [7:0]                     regRdData,        // read data
    output logic                           regRdValid,       // read pulse
    output logic                           cardOutputEnable, // outputs on
    output logic                           autoSwitchOn,     // auto mode
    output pcspc_pkg::pcspc_pwr_t          pwrCtrl,          // to switch
    output logic                           cardPowerStatus,  // power on
    output logic                           compatMode        // compat layout
);
    import pcspc_pkg::*;

    // ------------------------------------------------------------
    // layout selection
    // ------------------------------------------------------------
    logic [7:0]    identReg;
    logic [7:0]    powerCtrl;
    pcspc_layout_t layout;
    logic [7:0]    rwMask;
    logic [7:0]    keepMask;

    always_comb begin
        layout   = (identReg[3:0] == REV_COMPAT) ? LAYOUT_COMPAT : LAYOUT_NATIVE; // R12
        rwMask   = NATIVE_RW_MASK;
        keepMask = NATIVE_KEEP_MASK;
        if (layout == LAYOUT_COMPAT) begin
            rwMask   = COMPAT_RW_MASK; // R9
            keepMask = COMPAT_KEEP_MASK;
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic wrIdent;
    logic wrPower;

    assign wrIdent = regReq.wrEn && (regReq.addr == OFS_IDENT);
    assign wrPower = regReq.wrEn && (regReq.addr == OFS_POWER_CTRL);

    // identification bits clear on global reset only
    pcspc_dual_reset_reg #(
        .W         (8),
        .RESET_VAL (IDENT_RESET)
    ) u_ident (
        .clock     (clock),
        .rst       (rst),
        .busReset  (busReset),
        .pmeEnable (1'b1),
        .wrEn      (wrIdent),
        .wrData    (regReq.wrData),
        .wrMask    (IDENT_RW_MASK),
        .keepMask  (IDENT_RW_MASK),
        .q         (identReg)
    ); // R12

    // marked bits survive bus reset while events are enabled
    pcspc_dual_reset_reg #(
        .W         (8),
        .RESET_VAL (POWER_CTRL_RESET)
    ) u_power (
        .clock     (clock),
        .rst       (rst),
        .busReset  (busReset),
        .pmeEnable (pmeEnable),
        .wrEn      (wrPower),
        .wrData    (regReq.wrData),
        .wrMask    (rwMask),
        .keepMask  (keepMask),
        .q         (powerCtrl)
    ); // R11

    // ------------------------------------------------------------
    // power decode
    // ------------------------------------------------------------
    logic       cardSeated;
    pcspc_pwr_t pwrDecoded;

    assign cardSeated = !cardDetect1N && !cardDetect2N;

    pcspc_power_decode u_decode (
        .layout         (layout),
        .ctrl           (powerCtrl),
        .vccLevelSelect (vccLevelSelect),
        .cardSeated     (cardSeated),
        .pwr            (pwrDecoded)
    );

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic       cardOutputEnable_ff;
    logic       autoSwitchOn_ff;
    pcspc_pwr_t pwrCtrl_ff;
    logic       cardPowerStatus_ff;
    logic       compatMode_ff;
    logic       nxt_cardOutputEnable;
    logic       nxt_autoSwitchOn;
    pcspc_pwr_t nxt_pwrCtrl;
    logic       nxt_cardPowerStatus;
    logic       nxt_compatMode;

    always_comb begin
        nxt_cardOutputEnable = powerCtrl[PC_OUT_EN_BIT]; // R1
        nxt_autoSwitchOn     = (layout == LAYOUT_NATIVE) && powerCtrl[PC_AUTO_SW_BIT]; // R3
        nxt_pwrCtrl          = pwrDecoded; // R14
        nxt_cardPowerStatus  = pwrDecoded.vccOn; // R13
        nxt_compatMode       = (layout == LAYOUT_COMPAT);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cardOutputEnable_ff <= 1'b0;
            autoSwitchOn_ff     <= 1'b0;
            pwrCtrl_ff          <= '0;
            cardPowerStatus_ff  <= 1'b0;
            compatMode_ff       <= 1'b0;
        end else begin
            cardOutputEnable_ff <= nxt_cardOutputEnable;
            autoSwitchOn_ff     <= nxt_autoSwitchOn;
            pwrCtrl_ff          <= nxt_pwrCtrl;
            cardPowerStatus_ff  <= nxt_cardPowerStatus;
            compatMode_ff       <= nxt_compatMode;
        end
    end

    assign cardOutputEnable = cardOutputEnable_ff;
    assign autoSwitchOn     = autoSwitchOn_ff;
    assign pwrCtrl          = pwrCtrl_ff;
    assign cardPowerStatus  = cardPowerStatus_ff;
    assign compatMode       = compatMode_ff;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rdValue;
    logic [7:0] regRdData_ff;
    logic       regRdValid_ff;
    logic [7:0] nxt_regRdData;
    logic       nxt_regRdValid;

    always_comb begin
        rdValue = 8'h00;
        unique case (regReq.addr)
            OFS_IDENT: begin
                rdValue = {IFTYPE_VAL, identReg[5:0]};
            end
            OFS_IF_STATUS: begin
                rdValue[ST_CARD_PWR_BIT] = cardPowerStatus_ff; // R13
                rdValue[ST_CD2_BIT]      = !cardDetect2N;
                rdValue[ST_CD1_BIT]      = !cardDetect1N;
            end
            OFS_POWER_CTRL: begin
                rdValue = powerCtrl & rwMask; // R2 R5 R9
            end
            default: begin
                rdValue = 8'h00;
            end
        endcase
        nxt_regRdValid = regReq.rdEn;
        nxt_regRdData  = regRdData_ff;
        if (regReq.rdEn) begin
            nxt_regRdData = rdValue;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            regRdData_ff  <= 8'h00;
            regRdValid_ff <= 1'b0;
        end else begin
            regRdData_ff  <= nxt_regRdData;
            regRdValid_ff <= nxt_regRdValid;
        end
    end

    assign regRdData  = regRdData_ff;
    assign regRdValid = regRdValid_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic rdPower;
    logic nativeNow;
    assign rdPower   = regReq.rdEn && (regReq.addr == OFS_POWER_CTRL);
    assign nativeNow = (layout == LAYOUT_NATIVE);

    sequence s_power_write;
        wrPower && !busReset;
    endsequence

    sequence s_write_settled;
        s_power_write ##1 !(busReset || wrPower);
    endsequence

    // a global reset in the previous cycle forces the enable low
    chk_out_en_follow: assert property ( // R1
        cardOutputEnable == ($past(powerCtrl[PC_OUT_EN_BIT]) && !$past(rst)))
        else $error("output enable does not follow stored bit");

    chk_native_bit6: assert property ( // R2
        rdPower && nativeNow |=> regRdValid && !regRdData[6])
        else $error("native bit 6 read nonzero");

    chk_auto_gate: assert property ( // R3
        nativeNow && powerCtrl[PC_AUTO_SW_BIT] && !cardSeated |=> !pwrCtrl.vccOn)
        else $error("auto switch left vcc on without card");

    chk_vcc_enable: assert property ( // R4
        nativeNow && powerCtrl[PC_VCC_EN_BIT] && !powerCtrl[PC_AUTO_SW_BIT]
        |=> pwrCtrl.vccOn && (pwrCtrl.vcc3v3 == $past(vccLevelSelect)))
        else $error("native vcc enable not applied");

    chk_vcc_off_native: assert property ( // R4
        nativeNow && !powerCtrl[PC_VCC_EN_BIT] |=> !pwrCtrl.vccOn)
        else $error("native vcc on with enable clear");

    chk_auto_flag: assert property ( // R3
        nativeNow && powerCtrl[PC_AUTO_SW_BIT] |=> autoSwitchOn)
        else $error("auto switch flag not shown");

    chk_native_rsvd: assert property ( // R5
        rdPower && nativeNow |=> regRdData[3:2] == 2'h0)
        else $error("native bits 3:2 read nonzero");

    chk_vpp_12v: assert property ( // R6
        pwrDecoded.vccOn && powerCtrl[1:0] == VPP_12V
        |=> pwrCtrl.vpp12 && !pwrCtrl.vppFollow)
        else $error("vpp 12 V request not decoded");

    chk_vpp_gated: assert property ( // R7
        !pwrCtrl.vccOn |-> !pwrCtrl.vpp12 && !pwrCtrl.vppFollow)
        else $error("vpp driven with vcc off");

    chk_compat_vcc: assert property ( // R8
        !nativeNow && powerCtrl[4:3] == VCC_REQ_3V3 |=> pwrCtrl.vccOn && pwrCtrl.vcc3v3)
        else $error("compat 3.3 V not decoded");

    chk_compat_5v: assert property ( // R8
        !nativeNow && powerCtrl[4:3] == VCC_REQ_5V |=> pwrCtrl.vccOn && !pwrCtrl.vcc3v3)
        else $error("compat 5 V not decoded");

    chk_compat_rsvd: assert property ( // R9
        rdPower && !nativeNow |=> regRdData[6:5] == 2'h0 && !regRdData[2])
        else $error("compat reserved bits read nonzero");

    chk_compat_vpp: assert property ( // R10
        !nativeNow && powerCtrl[4:3] == VCC_REQ_0V |=> !pwrCtrl.vpp12 && !pwrCtrl.vppFollow)
        else $error("compat vpp active with 0 V vcc");

    chk_pme_keep: assert property ( // R11
        busReset && pmeEnable |=> (powerCtrl & $past(keepMask)) == $past(powerCtrl & keepMask))
        else $error("marked bits lost on bus reset");

    chk_bus_clear: assert property ( // R11
        busReset && !pmeEnable |=> powerCtrl == POWER_CTRL_RESET)
        else $error("bus reset did not clear register");

    chk_rev_select: assert property ( // R12
        wrIdent && !busReset && regReq.wrData[3:0] == REV_COMPAT |=> ##1 compatMode)
        else $error("compat layout not selected");

    chk_rev_reset: assert property ( // R12
        $fell(rst) |-> identReg[3:0] == REV_NATIVE && !compatMode)
        else $error("revision not native after reset");

    chk_status_pwr: assert property ( // R13
        regReq.rdEn && regReq.addr == OFS_IF_STATUS
        |=> regRdData[ST_CARD_PWR_BIT] == $past(cardPowerStatus))
        else $error("status bit 6 mismatch");

    // stored at the write edge, output flop follows one edge later
    chk_write_update: assert property ( // R14
        s_write_settled |=> cardOutputEnable == $past(regReq.wrData[PC_OUT_EN_BIT], 2))
        else $error("outputs not updated after write");

endmodule

// ==== verif/pcspc_socket_model.sv ====
// socket power switch and 16-bit card model for the power control bench
// assumes switch requests are steady levels; detects pulled up with no card
`timescale 1ns/1ps
module pcspc_socket_model (
    input  wire pcspc_pkg::pcspc_pwr_t pwrCtrl,      // switch requests
    input  wire logic [1:0]            insertLevel,  // 0 out, 1 partial, 2 seated
    output logic                       cardDetect1N, // detect 1
    output logic                       cardDetect2N, // detect 2
    output int                         vccMv,        // socket vcc in mV
    output int                         vppMv         // socket vpp in mV
);
    import pcspc_pkg::*;

    // partial insertion grounds one detect only
    always_comb begin
        cardDetect1N = (insertLevel == 2'h0);
        cardDetect2N = (insertLevel != 2'h2);
        vccMv        = pwrCtrl.vccOn ? (pwrCtrl.vcc3v3 ? 3300 : 5000) : 0;
        vppMv        = pwrCtrl.vpp12 ? 12000 : (pwrCtrl.vppFollow ? vccMv : 0);
    end
endmodule

// ==== verif/pcspc_socket_power_tb.sv ====
// self-checking bench for the socket power control register bank
// assumes pcspc_pkg compiled first; the socket model drives the detects
`timescale 1ns/1ps
module pcspc_socket_power_tb;
    import pcspc_pkg::*;
    logic           clock = 1'b0;
    logic           rst = 1'b1;
    logic           busReset = 1'b0;
    logic           pmeEnable = 1'b0;
    pcspc_reg_req_t regReq = '0;
    logic           vccLevelSelect = 1'b0;
    logic [1:0]     insertLevel = 2'h0;
    logic           cardDetect1N;
    logic           cardDetect2N;
    logic [7:0]     regRdData;
    logic           regRdValid;
    logic           cardOutputEnable;
    logic           autoSwitchOn;
    pcspc_pwr_t     pwrCtrl;
    logic           cardPowerStatus;
    logic           compatMode;
    int             vccMv;
    int             vppMv;
    int             n_fail = 0;
    int             n_tests = 0;
    int             seed = 32'h7cb2;
    logic [7:0]     pw = 8'h00;
    logic           cm = 1'b0;

    always #5 clock = ~clock;

    pcspc_socket_power i_pcspc_socket_power (
        .clock(clock), .rst(rst), .busReset(busReset), .pmeEnable(pmeEnable),
        .regReq(regReq), .vccLevelSelect(vccLevelSelect),
        .cardDetect1N(cardDetect1N), .cardDetect2N(cardDetect2N),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .cardOutputEnable(cardOutputEnable), .autoSwitchOn(autoSwitchOn),
        .pwrCtrl(pwrCtrl), .cardPowerStatus(cardPowerStatus), .compatMode(compatMode)
    );

    pcspc_socket_model i_pcspc_socket_model (
        .pwrCtrl(pwrCtrl), .insertLevel(insertLevel), .cardDetect1N(cardDetect1N),
        .cardDetect2N(cardDetect2N), .vccMv(vccMv), .vppMv(vppMv)
    );

    // packs {oe, auto, vccOn, vcc3v3, follow, 12 V, 00}
    function automatic logic [7:0] expOut(input logic [7:0] r, input logic c,
                                          input logic seat, input logic sel);
        logic on;
        logic v3;
        on = c ? r[4] : (r[4] && (!r[5] || seat));
        v3 = c ? (r[4] && r[3]) : (on && sel);
        return {r[7], !c && r[5], on, v3, on && r[1:0] == 2'h1, on && r[1:0] == 2'h2, 2'h0};
    endfunction

    function automatic logic [7:0] rdMask();
        return cm ? COMPAT_RW_MASK : NATIVE_RW_MASK;
    endfunction

    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regReq = '{1'b1, 1'b0, a, d};
        if (a == OFS_POWER_CTRL) begin
            pw = (pw & ~rdMask()) | (d & rdMask());
        end
        @(negedge clock);
        regReq = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        regReq = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clock);
        regReq = '0;
        chk({7'h00, regRdValid}, 8'h01, "read valid");
        chk(regRdData, exp, "read data");
    endtask

    task automatic chkOuts(input logic [7:0] e, input string what);
        int vcc;
        int vpp;
        vcc = e[5] ? (e[4] ? 3300 : 5000) : 0;
        vpp = e[2] ? 12000 : (e[3] ? vcc : 0);
        chk({cardOutputEnable, autoSwitchOn, pwrCtrl.vccOn, pwrCtrl.vcc3v3,
             pwrCtrl.vppFollow, pwrCtrl.vpp12, 2'h0}, e, what);
        chk({6'h00, cardPowerStatus, vccMv == vcc && vppMv == vpp}, {6'h00, e[5], 1'b1}, what);
    endtask

    // every value of the power byte with random detects and level select
    task automatic sweep();
        logic [7:0] e;
        logic       seat;
        for (int i = 0; i < 256; i++) begin
            @(negedge clock);
            insertLevel = 2'({$random(seed)} % 3);
            vccLevelSelect = 1'($random(seed));
            seat = (insertLevel == 2'h2);
            e = expOut(pw, cm, seat, vccLevelSelect);
            wr(OFS_POWER_CTRL, 8'(i));
            chkOuts(e, "outputs before update");
            @(negedge clock);
            e = expOut(pw, cm, seat, vccLevelSelect);
            chkOuts(e, "outputs");
            rd(OFS_POWER_CTRL, pw & rdMask());
            rd(OFS_IF_STATUS, {1'b0, e[5], 2'h0, seat, insertLevel != 2'h0, 2'h0});
        end
    endtask

    task automatic busRst(input logic pme);
        wr(OFS_POWER_CTRL, 8'hFF);
        pmeEnable = pme;
        @(negedge clock);
        busReset = 1'b1;
        @(negedge clock);
        busReset = 1'b0;
        pw = pme ? (pw & (cm ? COMPAT_KEEP_MASK : NATIVE_KEEP_MASK)) : 8'h00;
        rd(OFS_POWER_CTRL, pw & rdMask());
    endtask

    initial begin
        #400000;
        n_fail++;
        conclude();
    end

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        chkOuts(8'h00, "reset outputs");
        rd(OFS_IDENT, 8'h84);
        rd(OFS_POWER_CTRL, POWER_CTRL_RESET);
        sweep();
        busRst(1'b1);
        busRst(1'b0);
        wr(OFS_IF_STATUS, 8'hFF);
        rd(8'h05, 8'h00);
        rd(OFS_POWER_CTRL, 8'h00);
        wr(OFS_IDENT, {4'h0, REV_COMPAT});
        @(negedge clock);
        cm = 1'b1;
        chk({7'h00, compatMode}, 8'h01, "compat mode");
        rd(OFS_IDENT, 8'h82);
        sweep();
        busRst(1'b1);
        busRst(1'b0);
        rd(OFS_IDENT, 8'h82);
        wr(OFS_POWER_CTRL, 8'h9B);
        pmeEnable = 1'b1;
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        pw = 8'h00;
        cm = 1'b0;
        @(negedge clock);
        chk({7'h00, compatMode}, 8'h00, "native after reset");
        rd(OFS_IDENT, 8'h84);
        rd(OFS_POWER_CTRL, 8'h00);
        conclude();
    end
endmodule
